/* File: pcs_addr_gen.sv */
// Program counter, page latch, return stack and indirect data address block.
// Assumes core command inputs are synchronous one-cycle strobes, at most one per cycle,
// and a single AXI4-Lite master with one write and one read outstanding at most.
`timescale 1ns/1ps
// Contract
// - Thirteen-bit program counter; low byte read/write.
// - Upper five bits unreadable, written via latch.
// - Every reset clears the upper counter bits.
// - Low byte write loads upper bits from latch.
// - Call/jump: eleven instruction bits, latch page bits.
// - Continuous 8K space in 2K pages.
// - Small parts ignore latch bit four.
// - Eight-deep 13-bit stack, pointer hidden.
// - Push on call or interrupt vectoring.
// - Pop full counter on any return.
// - Push and pop leave latch untouched.
// - Stack wraps, overwriting oldest entries.
// - No overflow or underflow status.
// - Indirect port redirects to pointed register.
// - Indirect self read returns 00h.
// - Indirect self write changes no register.
// - Indirect address is bank bit plus pointer.
module pcs_addr_gen
  import pcs_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // AXI4-Lite slave.
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [AXI_DW-1:0]   s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [AXI_DW-1:0]        s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  // Core program flow commands.
  input  wire logic                step_i,
  input  wire logic                goto_i,
  input  wire logic                call_i,
  input  wire logic                irq_i,
  input  wire logic                ret_i,
  input  wire logic [TARGET_W-1:0] target_i,
  input  wire logic                low_wr_i,
  input  wire logic [LOW_W-1:0]    low_data_i,
  // Core data access.
  input  wire logic                dacc_valid_i,
  input  wire logic                dacc_write_i,
  input  wire logic [DADDR_W-1:0]  dacc_addr_i,
  input  wire logic [DATA_W-1:0]   dacc_wdata_i,
  output logic [PC_W-1:0]          pc_o,
  output logic                     mem_valid_o,
  output logic                     mem_write_o,
  output logic [DADDR_W-1:0]       mem_addr_o,
  output logic [DATA_W-1:0]        mem_wdata_o,
  output logic                     zero_read_o
);

  logic [PC_W-1:0]        pc_q;
  logic [PC_W-1:0]        pc_d;
  logic [HIGH_W-1:0]      high_q;
  logic [HIGH_W-1:0]      high_d;
  logic [DATA_W-1:0]      fsp_q;
  logic [DATA_W-1:0]      fsp_d;
  logic                   bank_q;
  logic                   bank_d;
  logic                   wide_q;
  logic                   wide_d;

  pcs_wr_state_type       wr_state_q;
  pcs_wr_state_type       wr_state_d;
  logic                   have_aw_q;
  logic                   have_aw_d;
  logic                   have_w_q;
  logic                   have_w_d;
  logic [AXI_AW-1:0]      waddr_q;
  logic [AXI_AW-1:0]      waddr_d;
  logic [DATA_W-1:0]      wdata_q;
  logic [DATA_W-1:0]      wdata_d;
  logic                   wlane_q;
  logic                   wlane_d;
  logic                   awready_q;
  logic                   awready_d;
  logic                   wready_q;
  logic                   wready_d;
  logic                   bvalid_q;
  logic                   bvalid_d;
  logic [1:0]             bresp_q;
  logic [1:0]             bresp_d;
  logic                   arready_q;
  logic                   arready_d;
  logic                   rvalid_q;
  logic                   rvalid_d;
  logic [AXI_DW-1:0]      rdata_q;
  logic [AXI_DW-1:0]      rdata_d;
  logic [1:0]             rresp_q;
  logic [1:0]             rresp_d;

  logic                   mvalid_q;
  logic                   mvalid_d;
  logic                   mwrite_q;
  logic                   mwrite_d;
  logic [DADDR_W-1:0]     maddr_q;
  logic [DADDR_W-1:0]     maddr_d;
  logic [DATA_W-1:0]      mwdata_q;
  logic [DATA_W-1:0]      mwdata_d;
  logic                   zread_q;
  logic                   zread_d;

  logic                   core_busy;
  logic                   push;
  logic                   pop;
  logic [PC_W-1:0]        stack_top;
  logic [HIGH_W-1:0]      upper_src;
  logic [1:0]             page_src;
  logic                   waddr_ok;
  logic                   apply_low;
  logic                   aw_take;
  logic                   w_take;

  pcs_return_stack u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i (pc_q),
    .top_o       (stack_top)
  );

  // A part with the narrow memory drops the top page bit from every latch load.
  assign upper_src = {high_q[HIGH_PAGE_HI] & wide_q, high_q[HIGH_PAGE_HI-1:0]};
  assign page_src  = {high_q[HIGH_PAGE_HI] & wide_q, high_q[HIGH_PAGE_LO]};

  assign core_busy = irq_i | call_i | goto_i | ret_i | low_wr_i | step_i;
  assign push      = irq_i | (call_i & ~irq_i);
  assign pop       = ret_i & ~irq_i & ~call_i & ~goto_i;

  assign waddr_ok  = (waddr_q == OFS_PC_LOW) || (waddr_q == OFS_PC_HIGH) ||
                     (waddr_q == OFS_FSP) || (waddr_q == OFS_STATUS) ||
                     (waddr_q == OFS_CONFIG);
  // A bus write of the low byte waits for a cycle with no core command of any kind, so the
  // two never race for the counter.
  assign apply_low = (wr_state_q == WR_APPLY) && (waddr_q == OFS_PC_LOW) &&
                     wlane_q && !core_busy;

  // Program counter. The latch is never touched by stack traffic.
  always_comb begin
    pc_d = pc_q;
    if (irq_i) begin
      pc_d = IRQ_VECTOR;
    end else if (call_i || goto_i) begin
      pc_d = {page_src, target_i};
    end else if (ret_i) begin
      pc_d = stack_top;
    end else if (low_wr_i) begin
      pc_d = {upper_src, low_data_i};
    end else if (step_i) begin
      pc_d = {pc_q[UPPER_PC_TOP:UPPER_PC_BOT], pc_q[LOW_W-1:0] + LOW_ONE};
    end else if (apply_low) begin
      pc_d = {upper_src, wdata_q};
    end
  end

  // Software-visible registers.
  always_comb begin
    high_d = high_q;
    fsp_d  = fsp_q;
    bank_d = bank_q;
    wide_d = wide_q;
    if (wr_state_q == WR_APPLY && wlane_q) begin
      if (waddr_q == OFS_PC_HIGH) begin
        high_d = wdata_q[HIGH_W-1:0];
      end else if (waddr_q == OFS_FSP) begin
        fsp_d = wdata_q;
      end else if (waddr_q == OFS_STATUS) begin
        bank_d = wdata_q[STATUS_BANK];
      end else if (waddr_q == OFS_CONFIG) begin
        wide_d = wdata_q[CONFIG_WIDE];
      end
    end
  end

  // AXI write channel: address and data are taken in either order.
  assign aw_take = s_axi_awvalid_i && awready_q;
  assign w_take  = s_axi_wvalid_i && wready_q;

  always_comb begin
    wr_state_d = wr_state_q;
    have_aw_d  = have_aw_q;
    have_w_d   = have_w_q;
    waddr_d    = waddr_q;
    wdata_d    = wdata_q;
    wlane_d    = wlane_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    case (wr_state_q)
      WR_IDLE: begin
        if (aw_take) begin
          have_aw_d = 1'b1;
          waddr_d   = s_axi_awaddr_i;
        end
        if (w_take) begin
          have_w_d = 1'b1;
          wdata_d  = s_axi_wdata_i[DATA_W-1:0];
          wlane_d  = s_axi_wstrb_i[0];
        end
        if (have_aw_d && have_w_d) begin
          wr_state_d = WR_APPLY;
        end
      end
      WR_APPLY: begin
        if (!(waddr_q == OFS_PC_LOW && wlane_q && core_busy)) begin
          wr_state_d = WR_RESP;
          bvalid_d   = 1'b1;
          bresp_d    = waddr_ok ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (s_axi_bready_i) begin
          wr_state_d = WR_IDLE;
          bvalid_d   = 1'b0;
          have_aw_d  = 1'b0;
          have_w_d   = 1'b0;
        end
      end
      default: begin
        wr_state_d = WR_IDLE;
      end
    endcase
    awready_d = (wr_state_d == WR_IDLE) && !have_aw_d;
    wready_d  = (wr_state_d == WR_IDLE) && !have_w_d;
  end

  // AXI read channel. The upper counter bits and the stack pointer have no
  // read path at all.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end else if (s_axi_arvalid_i && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d  = '0;
      rresp_d  = RESP_OKAY;
      if (s_axi_araddr_i == OFS_PC_LOW) begin
        rdata_d[LOW_W-1:0] = pc_q[LOW_W-1:0];
      end else if (s_axi_araddr_i == OFS_PC_HIGH) begin
        rdata_d[HIGH_W-1:0] = high_q;
      end else if (s_axi_araddr_i == OFS_FSP) begin
        rdata_d[DATA_W-1:0] = fsp_q;
      end else if (s_axi_araddr_i == OFS_STATUS) begin
        rdata_d[STATUS_BANK] = bank_q;
      end else if (s_axi_araddr_i == OFS_CONFIG) begin
        rdata_d[CONFIG_WIDE] = wide_q;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  // Data access resolution: the indirect port is only an alias.
  always_comb begin
    mvalid_d = dacc_valid_i;
    mwrite_d = dacc_write_i;
    maddr_d  = dacc_addr_i;
    mwdata_d = dacc_wdata_i;
    zread_d  = 1'b0;
    if (dacc_valid_i && dacc_addr_i[6:0] == IND_PORT_ADDR) begin
      maddr_d = {bank_q, fsp_q};
      if (fsp_q == FSP_SELF) begin
        // Pointing back at the port itself: no storage is touched.
        mvalid_d = 1'b0;
        mwrite_d = 1'b0;
        zread_d  = !dacc_write_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q       <= PC_RST;
      high_q     <= HIGH_RST;
      fsp_q      <= FSP_RST;
      bank_q     <= BANK_RST;
      wide_q     <= WIDE_RST;
      wr_state_q <= WR_IDLE;
      have_aw_q  <= 1'b0;
      have_w_q   <= 1'b0;
      waddr_q    <= '0;
      wdata_q    <= '0;
      wlane_q    <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
      mvalid_q   <= 1'b0;
      mwrite_q   <= 1'b0;
      maddr_q    <= '0;
      mwdata_q   <= '0;
      zread_q    <= 1'b0;
    end else begin
      pc_q       <= pc_d;
      high_q     <= high_d;
      fsp_q      <= fsp_d;
      bank_q     <= bank_d;
      wide_q     <= wide_d;
      wr_state_q <= wr_state_d;
      have_aw_q  <= have_aw_d;
      have_w_q   <= have_w_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wlane_q    <= wlane_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      mvalid_q   <= mvalid_d;
      mwrite_q   <= mwrite_d;
      maddr_q    <= maddr_d;
      mwdata_q   <= mwdata_d;
      zread_q    <= zread_d;
    end
  end

  assign pc_o            = pc_q;
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign mem_valid_o     = mvalid_q;
  assign mem_write_o     = mwrite_q;
  assign mem_addr_o      = maddr_q;
  assign mem_wdata_o     = mwdata_q;
  assign zero_read_o     = zread_q;

endmodule

/* File: pcs_addr_gen_sva.sv */
// Concurrent checks on the core-facing ports of the address generator.
// Assumes the single core clock and the synchronous active-high reset of the block.
`timescale 1ns/1ps
module pcs_addr_gen_sva
  import pcs_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                step_i,
  input  wire logic                goto_i,
  input  wire logic                call_i,
  input  wire logic                irq_i,
  input  wire logic                ret_i,
  input  wire logic [TARGET_W-1:0] target_i,
  input  wire logic                low_wr_i,
  input  wire logic [LOW_W-1:0]    low_data_i,
  input  wire logic                dacc_valid_i,
  input  wire logic                dacc_write_i,
  input  wire logic [DADDR_W-1:0]  dacc_addr_i,
  input  wire logic [DATA_W-1:0]   dacc_wdata_i,
  input  wire logic [PC_W-1:0]     pc_o,
  input  wire logic                mem_valid_o,
  input  wire logic                mem_write_o,
  input  wire logic [DATA_W-1:0]   mem_wdata_o,
  input  wire logic                zero_read_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_clear: assert property (disable iff (1'h0) rst_i |=> pc_o == PC_RST)
    else $error("pc not cleared by reset");
  a_branch_target: assert property ((goto_i || call_i) && !irq_i
    |=> pc_o[TARGET_W-1:0] == $past(target_i)) else $error("branch target not taken");
  a_irq_vector: assert property (irq_i |=> pc_o == IRQ_VECTOR)
    else $error("interrupt did not vector");
  a_call_return: assert property ((call_i && !irq_i) ##1
    (ret_i && !irq_i && !call_i && !goto_i) |=> pc_o == $past(pc_o, 2))
    else $error("return did not restore caller pc");
  a_step_wrap: assert property (step_i && !(irq_i || call_i || goto_i || ret_i || low_wr_i)
    |=> pc_o == {$past(pc_o[12:8]), $past(pc_o[7:0]) + LOW_ONE}) else $error("bad increment");
  a_low_load: assert property (low_wr_i && !(irq_i || call_i || goto_i || ret_i)
    |=> pc_o[7:0] == $past(low_data_i)) else $error("low byte not loaded");
  a_zero_read: assert property (zero_read_o |-> !mem_valid_o &&
    $past(dacc_valid_i && !dacc_write_i && dacc_addr_i[6:0] == IND_PORT_ADDR))
    else $error("zero read without self read");
  a_mem_write: assert property (mem_valid_o && mem_write_o |->
    $past(dacc_valid_i && dacc_write_i) && mem_wdata_o == $past(dacc_wdata_i))
    else $error("resolved write has no cause");
  a_self_write: assert property (dacc_valid_i && dacc_write_i &&
    dacc_addr_i[6:0] == IND_PORT_ADDR |=> !zero_read_o) else $error("write gave zero read");

  c_call_ret: cover property (call_i ##1 ret_i);
  c_irq: cover property (irq_i);
  c_zero: cover property (zero_read_o);
  c_step: cover property (step_i);
endmodule
bind pcs_addr_gen pcs_addr_gen_sva u_sva (.clk_i, .rst_i, .step_i, .goto_i, .call_i, .irq_i,
  .ret_i, .target_i, .low_wr_i, .low_data_i, .dacc_valid_i, .dacc_write_i, .dacc_addr_i,
  .dacc_wdata_i, .pc_o, .mem_valid_o, .mem_write_o, .mem_wdata_o, .zero_read_o);

/* File: pcs_addr_gen_test.sv */
// Self-checking bench: register access over AXI4-Lite, core strobes and data accesses.
// Assumes the design package is compiled first and the data memory model sits on the far side.
`timescale 1ns/1ps
module pcs_addr_gen_test;
  import pcs_pkg::*;
  localparam int K_STEP = 0, K_GOTO = 1, K_CALL = 2, K_IRQ = 3, K_RET = 4, K_PCLW = 5;
  logic                clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic                s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic                s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [AXI_AW-1:0]   s_axi_awaddr_i, s_axi_araddr_i;
  logic [AXI_DW-1:0]   s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]          s_axi_wstrb_i;
  logic [1:0]          s_axi_bresp_o, s_axi_rresp_o, resp;
  logic                step_i, goto_i, call_i, irq_i, ret_i, low_wr_i, dacc_valid_i;
  logic                dacc_write_i, mem_valid_o, mem_write_o, zero_read_o;
  logic [TARGET_W-1:0] target_i;
  logic [LOW_W-1:0]    low_data_i;
  logic [DADDR_W-1:0]  dacc_addr_i, mem_addr_o;
  logic [DATA_W-1:0]   dacc_wdata_i, mem_wdata_o;
  logic [PC_W-1:0]     pc_o;
  logic [31:0]         wr_count;
  int                  num_errors, compares, cycles;

  pcs_addr_gen dut (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .step_i, .goto_i,
    .call_i, .irq_i, .ret_i, .target_i, .low_wr_i, .low_data_i, .dacc_valid_i, .dacc_write_i,
    .dacc_addr_i, .dacc_wdata_i, .pc_o, .mem_valid_o, .mem_write_o, .mem_addr_o,
    .mem_wdata_o, .zero_read_o);
  pcs_data_mem mem_model (.clk_i, .rst_i, .mem_valid_i(mem_valid_o), .mem_write_i(mem_write_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .wr_count_o(wr_count));

  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Handshakes are judged at the falling edge, so the value seen is the one the next
  // rising edge will sample, without racing the design's own registers.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'h0;
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_wstrb_i   <= s;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i  <= 1'h1;
    s_axi_bready_i  <= 1'h1;
    while (!b_hs) begin
      @(negedge clk_i);
      aw_hs = s_axi_awvalid_i && s_axi_awready_o;
      w_hs  = s_axi_wvalid_i && s_axi_wready_o;
      b_hs  = s_axi_bvalid_o;
      resp  = s_axi_bresp_o;
      @(posedge clk_i);
      if (aw_hs) s_axi_awvalid_i <= 1'h0;
      if (w_hs) s_axi_wvalid_i <= 1'h0;
    end
    s_axi_bready_i <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ar_hs, r_hs;
    r_hs = 1'h0;
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i  <= 1'h1;
    while (!r_hs) begin
      @(negedge clk_i);
      ar_hs = s_axi_arvalid_i && s_axi_arready_o;
      r_hs  = s_axi_rvalid_o;
      d     = s_axi_rdata_o;
      resp  = s_axi_rresp_o;
      @(posedge clk_i);
      if (ar_hs) s_axi_arvalid_i <= 1'h0;
    end
    s_axi_rready_i <= 1'h0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_rd(a, d);
    check(what, d, exp);
    check({what, " resp"}, resp, RESP_OKAY);
  endtask

  task automatic cmd(input int k, input logic [TARGET_W-1:0] t);
    @(posedge clk_i);
    target_i   <= t;
    low_data_i <= t[7:0];
    step_i     <= (k == K_STEP);
    goto_i     <= (k == K_GOTO);
    call_i     <= (k == K_CALL);
    irq_i      <= (k == K_IRQ);
    ret_i      <= (k == K_RET);
    low_wr_i   <= (k == K_PCLW);
    @(posedge clk_i);
    {step_i, goto_i, call_i, irq_i, ret_i, low_wr_i} <= 6'h00;
    #1;
  endtask

  task automatic dacc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    dacc_valid_i <= 1'h1;
    dacc_write_i <= w;
    dacc_addr_i  <= a;
    dacc_wdata_i <= d;
    @(posedge clk_i);
    dacc_valid_i <= 1'h0;
    #1;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    check("pc at reset", pc_o, 32'h0);
    rd_chk("low byte at reset", OFS_PC_LOW, 32'h0);
    axi_wr(OFS_PC_HIGH, 32'hFFFF_FFFF, 4'hF);
    rd_chk("latch", OFS_PC_HIGH, 32'h1F);
    axi_wr(OFS_PC_LOW, 32'hA5, 4'hF);
    check("pc after low write", pc_o, 13'h1FA5);
    rd_chk("low byte only", OFS_PC_LOW, 32'hA5);
    axi_wr(OFS_PC_LOW, 32'h11, 4'h0);
    check("pc after masked write", pc_o, 13'h1FA5);
    check("masked write resp", resp, RESP_OKAY);
    axi_wr(8'h40, 32'h11, 4'hF);
    check("unmapped write resp", resp, RESP_SLVERR);
    axi_rd(8'h14, d);
    check("unmapped read resp", resp, RESP_SLVERR);
  endtask

  task automatic t_flow;
    cmd(K_PCLW, 11'h0FF);
    check("core low write", pc_o, 13'h1FFF);
    cmd(K_STEP, 11'h000);
    check("step wraps in block", pc_o, 13'h1F00);
    axi_wr(OFS_PC_HIGH, 32'h0F, 4'hF);
    cmd(K_GOTO, 11'h7FF);
    check("goto page one", pc_o, 13'h0FFF);
    axi_wr(OFS_PC_HIGH, 32'h10, 4'hF);
    cmd(K_GOTO, 11'h123);
    check("goto page two", pc_o, 13'h1123);
    axi_wr(OFS_CONFIG, 32'h0, 4'hF);
    cmd(K_GOTO, 11'h123);
    check("small part goto", pc_o, 13'h0123);
    cmd(K_PCLW, 11'h0FF);
    check("small part low write", pc_o, 13'h00FF);
    axi_wr(OFS_CONFIG, 32'h1, 4'hF);
  endtask

  task automatic t_stack;
    logic [PC_W-1:0] pushed [11];
    logic [PC_W-1:0] exp_pc;
    axi_wr(OFS_PC_HIGH, 32'h0, 4'hF);
    cmd(K_GOTO, 11'h050);
    exp_pc = 13'h0050;
    for (int k = 1; k <= 10; k++) begin
      pushed[k] = exp_pc;
      cmd(K_CALL, TARGET_W'(11'h100 + k));
      exp_pc = PC_W'(13'h0100 + k);
      check("call target", pc_o, exp_pc);
    end
    rd_chk("latch after pushes", OFS_PC_HIGH, 32'h0);
    for (int k = 10; k >= 3; k--) begin
      cmd(K_RET, 11'h000);
      check("return", pc_o, pushed[k]);
    end
    cmd(K_RET, 11'h000);
    check("wrapped return", pc_o, pushed[10]);
    cmd(K_IRQ, 11'h000);
    check("interrupt vector", pc_o, IRQ_VECTOR);
    cmd(K_RET, 11'h000);
    check("return from interrupt", pc_o, pushed[10]);
    // A return straight after a call must pop the entry that call just pushed.
    @(posedge clk_i);
    call_i   <= 1'h1;
    target_i <= 11'h200;
    @(posedge clk_i);
    call_i <= 1'h0;
    ret_i  <= 1'h1;
    @(posedge clk_i);
    ret_i <= 1'h0;
    #1;
    check("back to back return", pc_o, pushed[10]);
    rd_chk("latch after pops", OFS_PC_HIGH, 32'h0);
  endtask

  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'h1;
    @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    #1;
    check("pc after second reset", pc_o, PC_RST);
    rd_chk("low byte after reset", OFS_PC_LOW, 32'h0);
  endtask

  task automatic t_indirect;
    logic [31:0] n;
    axi_wr(OFS_FSP, 32'hA5, 4'hF);
    axi_wr(OFS_STATUS, 32'h80, 4'hF);
    rd_chk("bank bit", OFS_STATUS, 32'h80);
    dacc(1'h0, 9'h000, 8'h00);
    check("indirect read addr", {mem_valid_o, zero_read_o, mem_addr_o}, 11'h5A5);
    dacc(1'h1, 9'h080, 8'h3C);
    check("indirect write addr", {mem_write_o, mem_addr_o}, 10'h3A5);
    @(posedge clk_i);
    #1;
    check("stored", mem_model.mem_q[9'h1A5], 8'h3C);
    axi_wr(OFS_FSP, 32'h0, 4'hF);
    axi_wr(OFS_STATUS, 32'h0, 4'hF);
    dacc(1'h0, 9'h000, 8'h00);
    check("self read", {mem_valid_o, zero_read_o}, 2'h1);
    n = wr_count;
    dacc(1'h1, 9'h000, 8'h77);
    check("self write", {mem_valid_o, zero_read_o}, 2'h0);
    @(posedge clk_i);
    #1;
    check("writes after self write", wr_count, n);
  endtask

  initial begin
    {rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 5'h10;
    {s_axi_rready_i, step_i, goto_i, call_i, irq_i, ret_i, low_wr_i, dacc_valid_i} = 8'h00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = 52'h0;
    {target_i, low_data_i, dacc_write_i, dacc_addr_i, dacc_wdata_i} = 37'h0;
    {num_errors, compares, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    #1;
    t_regs();
    t_flow();
    t_stack();
    t_reset();
    t_indirect();
    give_verdict();
  end
endmodule

/* File: pcs_data_mem.sv */
// Data memory standing for the core's register file behind the resolved accesses.
// Assumes accesses arrive as one-cycle strobes on the core clock.
`timescale 1ns/1ps
module pcs_data_mem
  import pcs_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               mem_valid_i,
  input  wire logic               mem_write_i,
  input  wire logic [DADDR_W-1:0] mem_addr_i,
  input  wire logic [DATA_W-1:0]  mem_wdata_i,
  output logic      [31:0]        wr_count_o
);
  logic [DATA_W-1:0] mem_q [2**DADDR_W];
  // The count lets the bench prove that a dropped write really touched nothing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_count_o <= 32'h0;
    end else if (mem_valid_i && mem_write_i) begin
      mem_q[mem_addr_i] <= mem_wdata_i;
      wr_count_o        <= wr_count_o + 32'h1;
    end
  end
endmodule

/* File: pcs_pkg.sv */
// Package for the program counter, return stack and indirect address block.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit core data path.
package pcs_pkg;

  localparam int PC_W      = 13;
  localparam int LOW_W     = 8;
  localparam int HIGH_W    = 5;
  localparam int TARGET_W  = 11;
  localparam int DATA_W    = 8;
  localparam int DADDR_W   = 9;
  localparam int STACK_D   = 8;
  localparam int STACK_PTR_W = 3;
  localparam int AXI_AW    = 8;
  localparam int AXI_DW    = 32;

  // Register byte addresses.
  localparam logic [AXI_AW-1:0] OFS_PC_LOW  = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_PC_HIGH = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_FSP     = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_STATUS  = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_CONFIG  = 8'h10;

  // Field positions.
  localparam int HIGH_PAGE_HI  = 4;
  localparam int HIGH_PAGE_LO  = 3;
  localparam int STATUS_BANK   = 7;
  localparam int CONFIG_WIDE   = 0;
  localparam int UPPER_PC_TOP  = 12;
  localparam int UPPER_PC_BOT  = 8;

  // Reset values.
  localparam logic [PC_W-1:0]    PC_RST     = 13'h0000;
  localparam logic [HIGH_W-1:0]  HIGH_RST   = 5'h00;
  localparam logic [DATA_W-1:0]  FSP_RST    = 8'h00;
  localparam logic               BANK_RST   = 1'b0;
  localparam logic               WIDE_RST   = 1'b1;

  // Core-side constants.
  localparam logic [PC_W-1:0]    IRQ_VECTOR    = 13'h0004;
  localparam logic [6:0]         IND_PORT_ADDR = 7'h00;
  localparam logic [DATA_W-1:0]  FSP_SELF      = 8'h00;
  localparam logic [LOW_W-1:0]   LOW_ONE       = 8'h01;
  localparam logic [STACK_PTR_W-1:0] PTR_ONE   = 3'h1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_APPLY,
    WR_RESP
  } pcs_wr_state_type;

endpackage

/* File: pcs_return_stack.sv */
// Eight-entry circular return stack held in flip-flops.
// Assumes the caller never asserts push and pop in the same cycle; push wins if it does.
`timescale 1ns/1ps
module pcs_return_stack
  import pcs_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            push_i,
  input  wire logic            pop_i,
  input  wire logic [PC_W-1:0] push_data_i,
  output logic      [PC_W-1:0] top_o
);

  logic [PC_W-1:0]        mem_q [STACK_D];
  logic [PC_W-1:0]        mem_d [STACK_D];
  logic [STACK_PTR_W-1:0] ptr_q;
  logic [STACK_PTR_W-1:0] ptr_d;

  // The pointer simply wraps, so overflow silently overwrites the oldest entry
  // and underflow reads stale data; nothing flags either case.
  always_comb begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    if (push_i) begin
      mem_d[ptr_q] = push_data_i;
      ptr_d        = ptr_q + PTR_ONE;
    end else if (pop_i) begin
      ptr_d = ptr_q - PTR_ONE;
    end
  end

  assign top_o = mem_q[ptr_q - PTR_ONE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= '0;
      for (int i = 0; i < STACK_D; i++) begin
        mem_q[i] <= PC_RST;
      end
    end else begin
      ptr_q <= ptr_d;
      mem_q <= mem_d;
    end
  end

endmodule
